// File: pkg/pcs_pkg.sv
package pcs_pkg;
  // Core widths and reset values
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int SP_W = 5;
  localparam int DEPTH = 16;
  localparam int BRA_W = 9;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [14:0] PC_ONE = 15'h0001;
  localparam logic [14:0] INT_VECTOR = 15'h0004;
  localparam logic [4:0] SP_RST = 5'h1F;
  localparam logic [4:0] SP_TOP = 5'h0F;
  localparam logic [6:0] LATCH_RST = 7'h00;
  localparam logic SFRE_RST = 1'b1;
  // Register byte offsets
  localparam logic [7:0] A_PCL = 8'h00;
  localparam logic [7:0] A_LATCH = 8'h04;
  localparam logic [7:0] A_SP = 8'h08;
  localparam logic [7:0] A_TOP_ENTRY_LOW = 8'h0C;
  localparam logic [7:0] A_TOP_ENTRY_HIGH = 8'h10;
  localparam logic [7:0] A_POWER_CONTROL_STATUS = 8'h14;
  localparam logic [7:0] A_CFG = 8'h18;
  localparam logic [7:0] A_FP0 = 8'h1C;
  localparam logic [7:0] A_FP1 = 8'h20;
  localparam logic [7:0] A_PC = 8'h24;
  // Field positions
  localparam int OVF_BIT = 0;
  localparam int UNF_BIT = 1;
  localparam int SFRE_BIT = 0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // File pointer map
  localparam logic [15:0] TRAD_LAST = 16'h0FFF;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29AF;
  localparam logic [11:0] GPR_OFS = 12'h020;
  localparam logic [11:0] GPR_SIZE = 12'h050;
  localparam logic [6:0] WIN_LAST = 7'h01;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SEQ = 4'h1,
    OP_WRPCL = 4'h2,
    OP_CALL = 4'h3,
    OP_CALL_FROM_WORKING = 4'h4,
    OP_BRW = 4'h5,
    OP_BRA = 4'h6,
    OP_RET = 4'h7,
    OP_RETURN_WITH_LITERAL = 4'h8,
    OP_RETURN_FROM_INTERRUPT = 4'h9,
    OP_INT = 4'hA,
    OP_WAKE = 4'hB
  } pcs_op_e;

  typedef enum logic [1:0] {
    RG_TRAD = 2'h0,
    RG_LIN = 2'h1,
    RG_PROG = 2'h2,
    RG_NONE = 2'h3
  } pcs_region_e;
endpackage

// File: hdl/pcs_fsr_map.sv
`timescale 1ns/1ps
// Turns a 16-bit file pointer into a memory region and address
module pcs_fsr_map (
  input wire logic [15:0] fsr,
  output pcs_pkg::pcs_region_e region,
  output logic [14:0] addr,
  output logic self_hit
);
  logic [11:0] off;
  logic [11:0] bank;
  logic [11:0] idx;

  // Linear space folds onto the 80-byte GENERAL_PURPOSE_RAM block of each bank
  always_comb begin
    off = fsr[11:0] - pcs_pkg::LIN_BASE[11:0];
    bank = off / pcs_pkg::GPR_SIZE;
    idx = off % pcs_pkg::GPR_SIZE;
    region = pcs_pkg::RG_NONE;
    addr = 15'h0000;
    self_hit = 1'b0;
    if (fsr[15]) begin
      region = pcs_pkg::RG_PROG; // [R20]
      addr = fsr[14:0];
    end else if (fsr <= pcs_pkg::TRAD_LAST) begin
      region = pcs_pkg::RG_TRAD; // [R17]
      addr = {3'h0, fsr[11:0]};
      self_hit = (fsr[6:0] <= pcs_pkg::WIN_LAST); // [R16]
    end else if (fsr >= pcs_pkg::LIN_BASE && fsr <= pcs_pkg::LIN_LAST) begin
      region = pcs_pkg::RG_LIN; // [R18]
      addr = {3'h0, ({bank[4:0], 7'h00} + pcs_pkg::GPR_OFS + idx)};
    end
  end
endmodule

// File: hdl/pcs_core.sv
`timescale 1ns/1ps
// What this block does
// R1: Keep a 15-bit PC; low byte readable, upper bits only from the latch.
// R2: Every restarting reset clears the whole PC to zero.
// R3: Writing the PC low byte loads upper bits from the latch at once.
// R4: Immediate call takes bits 10..0 from operand, 14..11 from latch 6..3.
// R5: Computed call loads low byte from working register, upper from latch.
// R6: Register branch loads PC+1 plus unsigned working register, any boundary.
// R7: Immediate branch loads PC+1 plus sign-extended operand.
// R8: Return stack of sixteen 15-bit entries, apart from memories.
// R9: Calls and interrupt vectoring push; the three returns pop.
// R10: Push and pop leave the PC high latch untouched.
// R11: With fault reset disabled the stack is circular.
// R12: Software reads and writes a 5-bit pointer and the top entry.
// R13: Pointer marks entry in use; push increments then writes, pop reverses.
// R14: With fault reset enabled, overflow or underflow resets and sets a flag.
// R15: Window access goes to the address formed by its file pointer pair.
// R16: Pointer at a window register reads zero and drops writes.
// R17: Pointer 0x000 to 0xFFF maps to absolute banked data addresses.
// R18: Pointer 0x2000 to 0x29AF maps contiguously onto 80-byte GENERAL_PURPOSE_RAM blocks.
// R19: Unimplemented linear-region locations read 0x00.
// R20: Pointer MSB set reads program memory low byte; writes ignored.
// R21: Program memory reads through the window take one extra cycle.
// R22: Interrupt wake with global enable runs next op, then vectors to 0004h.
// R23: Stack pointer resets to all ones, the empty mark.
// R24: High latch is a 7-bit readable buffer reset to zero.
// R25: Sequential execution advances the PC by one, wrapping.
module pcs_core #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic op_valid,
  input wire pcs_pkg::pcs_op_e op_code,
  input wire logic [10:0] op_operand,
  input wire logic [7:0] work_reg,
  input wire logic global_interrupt_enable,
  input wire logic restart_req,
  output logic [14:0] pc_out,
  output logic stack_reset,
  input wire logic ind_valid,
  input wire logic ind_sel,
  input wire logic ind_write,
  output logic [14:0] mem_addr,
  output logic [1:0] mem_region,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic [13:0] prog_word,
  input wire logic [7:0] data_byte,
  output logic [7:0] ind_rdata,
  output logic ind_done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACC = 2'h1,
    ST_XTRA = 2'h2
  } pcs_ind_e;

  localparam int PC_W = pcs_pkg::PC_W;

  logic [14:0] pc_reg, pc_next, pc_inc, push_val;
  logic [6:0] pc_high_latch_reg;
  logic [4:0] sp_reg, sp_up, sp_dn;
  logic [14:0] stk [pcs_pkg::DEPTH];
  logic sfre_reg, ovf_reg, unf_reg, pend_reg, int_now_reg;
  logic [15:0] fp_reg [2];
  logic restart, take, want_push, want_pop, ovf_hit, unf_hit, fault;
  logic do_push, do_pop;
  logic wr_en, rd_en, rd_ok, wr_ok;
  logic [31:0] rd_val;
  logic [14:0] tos;
  pcs_ind_e ist_reg;
  pcs_pkg::pcs_region_e map_rg;
  logic [14:0] map_addr;
  logic map_self, zero_reg;

  assign restart = restart_req || stack_reset;
  assign pc_inc = pc_reg + pcs_pkg::PC_ONE;
  assign sp_up = sp_reg + 5'h01;
  assign sp_dn = sp_reg - 5'h01;
  assign tos = stk[sp_reg[3:0]];
  assign take = int_now_reg || (op_valid && op_code != pcs_pkg::OP_NONE);
  assign wr_en = awready && awvalid && wvalid;
  assign rd_en = arready && arvalid;
  assign pc_out = pc_reg;

  // Next PC and stack action for the operation in hand
  always_comb begin
    pc_next = pc_reg;
    push_val = pc_inc;
    want_push = 1'b0;
    want_pop = 1'b0;
    if (int_now_reg) begin
      want_push = 1'b1; // [R9] [R22]
      push_val = pc_reg;
      pc_next = pcs_pkg::INT_VECTOR;
    end else if (op_valid) begin
      unique case (op_code)
        pcs_pkg::OP_NONE, pcs_pkg::OP_WAKE: pc_next = pc_reg;
        pcs_pkg::OP_SEQ: pc_next = pc_inc; // [R25]
        pcs_pkg::OP_WRPCL: pc_next = {pc_high_latch_reg, op_operand[7:0]}; // [R3]
        pcs_pkg::OP_CALL: begin
          pc_next = {pc_high_latch_reg[6:3], op_operand}; // [R4]
          want_push = 1'b1; // [R9]
        end
        pcs_pkg::OP_CALL_FROM_WORKING: begin
          pc_next = {pc_high_latch_reg, work_reg}; // [R5]
          want_push = 1'b1;
        end
        pcs_pkg::OP_BRW: pc_next = pc_inc + {7'h00, work_reg}; // [R6]
        pcs_pkg::OP_BRA: pc_next = pc_inc + {{6{op_operand[8]}}, op_operand[8:0]}; // [R7]
        pcs_pkg::OP_RET, pcs_pkg::OP_RETURN_WITH_LITERAL, pcs_pkg::OP_RETURN_FROM_INTERRUPT: begin
          pc_next = tos; // [R13]
          want_pop = 1'b1; // [R9]
        end
        pcs_pkg::OP_INT: begin
          pc_next = pcs_pkg::INT_VECTOR;
          push_val = pc_reg;
          want_push = 1'b1;
        end
        default: pc_next = pc_reg;
      endcase
    end
  end

  // Fault detection: push with pointer from 0Fh to 1Eh is overflow, pop with pointer at 1Fh underflow
  assign ovf_hit = want_push && sfre_reg && sp_reg >= pcs_pkg::SP_TOP
                   && sp_reg != pcs_pkg::SP_RST; // [R14]
  assign unf_hit = want_pop && sfre_reg && sp_reg == pcs_pkg::SP_RST; // [R14]
  assign fault = (ovf_hit || unf_hit) && !restart;
  assign do_push = want_push && !ovf_hit && !restart;
  assign do_pop = want_pop && !unf_hit && !restart;

  // Program counter
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pc_reg <= pcs_pkg::PC_RST; // [R2]
    end else if (fault) begin
      pc_reg <= pc_reg;
    end else if (take) begin
      pc_reg <= pc_next;
    end else if (wr_en && awaddr == AW'(pcs_pkg::A_PCL) && wstrb[0]) begin
      pc_reg <= {pc_high_latch_reg, wdata[7:0]}; // [R1] [R3]
    end
  end

  // High latch, written by software only
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pc_high_latch_reg <= pcs_pkg::LATCH_RST; // [R24]
    end else if (wr_en && awaddr == AW'(pcs_pkg::A_LATCH) && wstrb[0]) begin
      pc_high_latch_reg <= wdata[6:0]; // [R10]
    end
  end

  // Stack pointer
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      sp_reg <= pcs_pkg::SP_RST; // [R23]
    end else if (do_push) begin
      sp_reg <= sp_up; // [R13] [R11]
    end else if (do_pop) begin
      sp_reg <= sp_dn; // [R13]
    end else if (wr_en && awaddr == AW'(pcs_pkg::A_SP) && wstrb[0]) begin
      sp_reg <= wdata[4:0]; // [R12]
    end
  end

  // Stack entries; index wraps so with fault reset disabled the 17th push lands on entry 0
  always_ff @(posedge aclk) begin
    if (do_push) begin
      stk[sp_up[3:0]] <= push_val; // [R8] [R11]
    end else if (wr_en && awaddr == AW'(pcs_pkg::A_TOP_ENTRY_LOW) && wstrb[0]) begin
      stk[sp_reg[3:0]][7:0] <= wdata[7:0]; // [R12]
    end else if (wr_en && awaddr == AW'(pcs_pkg::A_TOP_ENTRY_HIGH) && wstrb[0]) begin
      stk[sp_reg[3:0]][14:8] <= wdata[6:0];
    end
  end

  // Fault reset pulse, sticky flags (set wins over clear) and config
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_reset <= 1'b0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      sfre_reg <= pcs_pkg::SFRE_RST;
    end else begin
      stack_reset <= fault; // [R14]
      if (wr_en && awaddr == AW'(pcs_pkg::A_POWER_CONTROL_STATUS) && wstrb[0]) begin
        ovf_reg <= ovf_reg && !wdata[pcs_pkg::OVF_BIT];
        unf_reg <= unf_reg && !wdata[pcs_pkg::UNF_BIT];
      end
      if (ovf_hit && !restart) ovf_reg <= 1'b1; // [R14]
      if (unf_hit && !restart) unf_reg <= 1'b1;
      if (wr_en && awaddr == AW'(pcs_pkg::A_CFG) && wstrb[0]) begin
        sfre_reg <= wdata[pcs_pkg::SFRE_BIT];
      end
    end
  end

  // Wake-up vectoring: one op runs, then a push and jump to the vector
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pend_reg <= 1'b0;
      int_now_reg <= 1'b0;
    end else begin
      int_now_reg <= 1'b0;
      if (op_valid && !int_now_reg && op_code == pcs_pkg::OP_WAKE) begin
        pend_reg <= global_interrupt_enable; // [R22]
      end else if (pend_reg && take && !int_now_reg && !fault) begin
        pend_reg <= 1'b0;
        int_now_reg <= 1'b1; // [R22]
      end
    end
  end

  // File pointer pairs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_reg[0] <= 16'h0000;
      fp_reg[1] <= 16'h0000;
    end else if (wr_en && (awaddr == AW'(pcs_pkg::A_FP0) || awaddr == AW'(pcs_pkg::A_FP1))) begin
      if (wstrb[0]) fp_reg[awaddr == AW'(pcs_pkg::A_FP1)][7:0] <= wdata[7:0];
      if (wstrb[1]) fp_reg[awaddr == AW'(pcs_pkg::A_FP1)][15:8] <= wdata[15:8];
    end
  end

  pcs_fsr_map u_map (
    .fsr(fp_reg[ind_sel]), // [R15]
    .region(map_rg),
    .addr(map_addr),
    .self_hit(map_self)
  );

  // Window access sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_reg <= ST_IDLE;
      mem_addr <= 15'h0000;
      mem_region <= 2'h0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      zero_reg <= 1'b0;
      ind_rdata <= 8'h00;
      ind_done <= 1'b0;
    end else begin
      ind_done <= 1'b0;
      unique case (ist_reg)
        ST_IDLE: if (ind_valid) begin
          mem_addr <= map_addr;
          mem_region <= map_rg;
          zero_reg <= map_self || map_rg == pcs_pkg::RG_NONE; // [R16] [R19]
          mem_rd <= !ind_write && !map_self && map_rg != pcs_pkg::RG_NONE;
          mem_wr <= ind_write && !map_self
                    && (map_rg == pcs_pkg::RG_TRAD || map_rg == pcs_pkg::RG_LIN); // [R20]
          ist_reg <= ST_ACC;
        end
        ST_ACC: if (mem_region == pcs_pkg::RG_PROG && mem_rd) begin
          ist_reg <= ST_XTRA; // [R21]
        end else begin
          ind_rdata <= (zero_reg || !mem_rd) ? 8'h00 : data_byte; // [R16]
          ind_done <= 1'b1;
          mem_rd <= 1'b0;
          mem_wr <= 1'b0;
          ist_reg <= ST_IDLE;
        end
        ST_XTRA: begin
          ind_rdata <= prog_word[7:0]; // [R20]
          ind_done <= 1'b1;
          mem_rd <= 1'b0;
          ist_reg <= ST_IDLE;
        end
        default: ist_reg <= ST_IDLE;
      endcase
    end
  end

  // Register read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (araddr)
      AW'(pcs_pkg::A_PCL): rd_val[7:0] = pc_reg[7:0]; // [R1]
      AW'(pcs_pkg::A_LATCH): rd_val[6:0] = pc_high_latch_reg; // [R24]
      AW'(pcs_pkg::A_SP): rd_val[4:0] = sp_reg; // [R12]
      AW'(pcs_pkg::A_TOP_ENTRY_LOW): rd_val[7:0] = tos[7:0];
      AW'(pcs_pkg::A_TOP_ENTRY_HIGH): rd_val[6:0] = tos[14:8];
      AW'(pcs_pkg::A_POWER_CONTROL_STATUS): rd_val[1:0] = {unf_reg, ovf_reg};
      AW'(pcs_pkg::A_CFG): rd_val[0] = sfre_reg;
      AW'(pcs_pkg::A_FP0): rd_val[15:0] = fp_reg[0];
      AW'(pcs_pkg::A_FP1): rd_val[15:0] = fp_reg[1];
      AW'(pcs_pkg::A_PC): rd_val[14:0] = pc_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (awaddr)
      AW'(pcs_pkg::A_PCL), AW'(pcs_pkg::A_LATCH), AW'(pcs_pkg::A_SP),
      AW'(pcs_pkg::A_TOP_ENTRY_LOW), AW'(pcs_pkg::A_TOP_ENTRY_HIGH), AW'(pcs_pkg::A_POWER_CONTROL_STATUS),
      AW'(pcs_pkg::A_CFG), AW'(pcs_pkg::A_FP0), AW'(pcs_pkg::A_FP1): wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // AXI4-Lite write channel: address and data taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= pcs_pkg::RESP_OKAY;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= pcs_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_en) begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic plain_op;
  assign plain_op = op_valid && !int_now_reg && !restart && !fault && !pend_reg;

  sequence fault_seq;
    stack_reset ##1 (sp_reg == pcs_pkg::SP_RST && pc_reg == pcs_pkg::PC_RST);
  endsequence

  pcl_write_a: assert property (wr_en && awaddr == AW'(pcs_pkg::A_PCL) && wstrb[0]
    && !take && !restart |=> pc_reg == {$past(pc_high_latch_reg), $past(wdata[7:0])}) // [R3]
    else $error("pc low write did not load latch and byte");
  call_target_a: assert property (plain_op && op_code == pcs_pkg::OP_CALL
    |=> pc_reg == {$past(pc_high_latch_reg[6:3]), $past(op_operand)}) // [R4]
    else $error("call target wrong");
  brw_target_a: assert property (plain_op && op_code == pcs_pkg::OP_BRW
    |=> pc_reg == $past(pc_reg) + PC_W'(1) + {7'h00, $past(work_reg)}) // [R6]
    else $error("register branch target wrong");
  push_sp_a: assert property (do_push |=> sp_reg == $past(sp_reg) + 5'h01) // [R13]
    else $error("pointer not incremented on push");
  stack_fault_a: assert property (fault |=> fault_seq) // [R14]
    else $error("stack fault did not reset pc and pointer");
  latch_hold_a: assert property ((do_push || do_pop)
    && !(wr_en && awaddr == AW'(pcs_pkg::A_LATCH)) |=> $stable(pc_high_latch_reg)) // [R10]
    else $error("latch moved on push or pop");
  circ_wrap_a: assert property (do_push && !sfre_reg && sp_reg == pcs_pkg::SP_TOP
    |=> sp_reg == 5'h10 && stk[0] == $past(push_val)) // [R11]
    else $error("circular push did not land on first entry");
  win_self_a: assert property (ist_reg == ST_IDLE && ind_valid && map_self
    |=> !mem_wr ##1 (ind_done && ind_rdata == 8'h00)) // [R16]
    else $error("window self access not suppressed");
  prog_extra_a: assert property (ist_reg == ST_IDLE && ind_valid && !ind_write
    && map_rg == pcs_pkg::RG_PROG |=> !ind_done [*2] ##1 ind_done) // [R21]
    else $error("program read lacks extra cycle");
endmodule

// File: dv/pcs_mem_model.sv
`timescale 1ns/1ps
// Program and data memory behind the window, answering while a read is open
module pcs_mem_model (
  input wire logic aclk,
  input wire logic [14:0] mem_addr,
  input wire logic mem_rd,
  output logic [13:0] prog_word,
  output logic [7:0] data_byte
);
  logic [7:0] pat_reg = 8'h00;
  // Idle pattern changes every cycle so a stale value never passes
  always @(posedge aclk) begin
    pat_reg <= pat_reg + 8'h3B;
  end
  // Contents follow the address so a wrong address shows in the data
  assign data_byte = mem_rd ? (mem_addr[7:0] ^ 8'hA5) : pat_reg;
  assign prog_word = mem_rd ? ~mem_addr[13:0] : {pat_reg, 6'h15};
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, work_reg = 0, data_byte, ind_rdata;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, stack_reset, mem_rd, mem_wr, ind_done;
  logic op_valid = 0, global_interrupt_enable = 0, restart_req = 0;
  logic ind_valid = 0, ind_sel = 0, ind_write = 0;
  logic [1:0] bresp, rresp, mem_region, rs;
  pcs_pkg::pcs_op_e op_code = pcs_pkg::OP_NONE;
  logic [10:0] op_operand = 0;
  logic [14:0] pc_out, mem_addr;
  logic [13:0] prog_word;
  int bad_count = 0;
  int tests_run = 0;
  int rst_cnt = 0;

  // 250 MHz core clock
  always #2 aclk = ~aclk;

  // Counts stack fault pulses
  always @(posedge aclk) if (stack_reset === 1'b1) rst_cnt <= rst_cnt + 1;

  pcs_core pcs_core_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .op_valid, .op_code, .op_operand, .work_reg,
    .global_interrupt_enable, .restart_req, .pc_out, .stack_reset, .ind_valid,
    .ind_sel, .ind_write, .mem_addr, .mem_region, .mem_rd, .mem_wr, .prog_word,
    .data_byte, .ind_rdata, .ind_done);

  pcs_mem_model pcs_mem_model_i (.aclk, .mem_addr, .mem_rd, .prog_word, .data_byte);

  // Value comparison
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write; address and data offered together, slave takes both at once
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd, wt;
    ad = 0;
    dd = 0;
    wt = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // Each channel is released only at the edge its own ready is seen
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        awvalid <= 0;
        wt = wready;
        ad = 1;
      end
      if (wready === 1'b1) begin
        wvalid <= 0;
        dd = 1;
      end
    end while (!(ad && dd));
    cmp("wready", 1, wt);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    rs = bresp;
  endtask

  // Bus read
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    rd = rdata;
    rs = rresp;
  endtask

  // Read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    cmp($sformatf("reg %h", a), e, rd);
  endtask

  // One decoder op with working register value
  task automatic op(input pcs_pkg::pcs_op_e c, input logic [10:0] x, input logic [7:0] w);
    @(posedge aclk);
    op_valid <= 1;
    op_code <= c;
    op_operand <= x;
    work_reg <= w;
    @(posedge aclk);
    op_valid <= 0;
    #1;
  endtask

  // Full jump through latch and low byte
  task automatic setpc(input logic [14:0] v);
    axw(pcs_pkg::A_LATCH, {25'h0, v[14:8]});
    op(pcs_pkg::OP_WRPCL, {3'h0, v[7:0]}, 8'h00);
  endtask

  // One window access with expected memory side and latency
  task automatic win(input logic [15:0] fp, input logic s, input logic w,
      input logic [14:0] ea, input logic [1:0] er, input logic erd, input logic ewr,
      input logic [7:0] ed, input int en);
    int n;
    axw(s ? pcs_pkg::A_FP1 : pcs_pkg::A_FP0, {16'h0000, fp});
    @(posedge aclk);
    ind_valid <= 1;
    ind_sel <= s;
    ind_write <= w;
    @(posedge aclk);
    ind_valid <= 0;
    #1;
    cmp("mem_rd", erd, mem_rd);
    cmp("mem_wr", ewr, mem_wr);
    if (erd || ewr) begin
      cmp("mem_addr", ea, mem_addr);
      cmp("region", er, mem_region);
    end
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (ind_done !== 1'b1);
    cmp("latency", en, n);
    if (!w) cmp("ind_rdata", ed, ind_rdata);
  endtask

  // Values after reset
  task automatic t_reset();
    cmp("pc", 0, pc_out);
    rdchk(pcs_pkg::A_SP, 32'h1F);
    rdchk(pcs_pkg::A_LATCH, 0);
    rdchk(pcs_pkg::A_CFG, 1);
    $display("test reset done");
  endtask

  // Jumps, calls and returns of every kind
  task automatic t_flow();
    setpc(15'h55A3);
    cmp("pc", 15'h55A3, pc_out);
    rdchk(pcs_pkg::A_PCL, 32'hA3);
    rdchk(pcs_pkg::A_LATCH, 32'h55);
    op(pcs_pkg::OP_CALL, 11'h7FF, 0);
    cmp("pc", 15'h57FF, pc_out);
    rdchk(pcs_pkg::A_SP, 0);
    rdchk(pcs_pkg::A_TOP_ENTRY_LOW, 32'hA4);
    rdchk(pcs_pkg::A_TOP_ENTRY_HIGH, 32'h55);
    rdchk(pcs_pkg::A_LATCH, 32'h55);
    op(pcs_pkg::OP_RET, 0, 0);
    cmp("pc", 15'h55A4, pc_out);
    rdchk(pcs_pkg::A_SP, 32'h1F);
    op(pcs_pkg::OP_CALL_FROM_WORKING, 0, 8'h3C);
    cmp("pc", 15'h553C, pc_out);
    op(pcs_pkg::OP_RETURN_WITH_LITERAL, 0, 0);
    cmp("pc", 15'h55A5, pc_out);
    op(pcs_pkg::OP_INT, 0, 0);
    cmp("pc", 15'h0004, pc_out);
    op(pcs_pkg::OP_RETURN_FROM_INTERRUPT, 0, 0);
    cmp("pc", 15'h55A5, pc_out);
    $display("test flow done");
  endtask

  // Relative branches across a 256-word boundary and wrap of the counter
  task automatic t_branch();
    setpc(15'h00FE);
    op(pcs_pkg::OP_BRW, 0, 8'hF0);
    cmp("pc", 15'h01EF, pc_out);
    op(pcs_pkg::OP_BRA, 11'h1FC, 0);
    cmp("pc", 15'h01EC, pc_out);
    op(pcs_pkg::OP_BRA, 11'h0FF, 0);
    cmp("pc", 15'h02EC, pc_out);
    setpc(15'h7FFF);
    op(pcs_pkg::OP_SEQ, 0, 0);
    cmp("pc", 0, pc_out);
    axw(pcs_pkg::A_PCL, 32'h5A);
    cmp("pc", 15'h7F5A, pc_out);
    rdchk(pcs_pkg::A_PC, 32'h7F5A);
    $display("test branch done");
  endtask

  // Overflow and underflow faults with fault reset enabled
  task automatic t_fault();
    int c0;
    c0 = rst_cnt;
    repeat (16) op(pcs_pkg::OP_CALL, 11'h010, 0);
    cmp("fault", 0, rst_cnt - c0);
    op(pcs_pkg::OP_CALL, 11'h010, 0);
    cmp("stack_reset", 1, stack_reset);
    @(posedge aclk);
    #1;
    cmp("pc", 0, pc_out);
    rdchk(pcs_pkg::A_POWER_CONTROL_STATUS, 1);
    rdchk(pcs_pkg::A_SP, 32'h1F);
    op(pcs_pkg::OP_RET, 0, 0);
    cmp("stack_reset", 1, stack_reset);
    rdchk(pcs_pkg::A_POWER_CONTROL_STATUS, 3);
    axw(pcs_pkg::A_POWER_CONTROL_STATUS, 3);
    rdchk(pcs_pkg::A_POWER_CONTROL_STATUS, 0);
    $display("test fault done");
  endtask

  // Circular stack and software access to the top entry
  task automatic t_circ();
    int c0;
    axw(pcs_pkg::A_CFG, 0);
    c0 = rst_cnt;
    for (int i = 0; i < 17; i++) op(pcs_pkg::OP_CALL, 11'(i), 0);
    cmp("fault", 0, rst_cnt - c0);
    axw(pcs_pkg::A_SP, 0);
    rdchk(pcs_pkg::A_TOP_ENTRY_LOW, 32'h10);
    rdchk(pcs_pkg::A_TOP_ENTRY_HIGH, 0);
    axw(pcs_pkg::A_TOP_ENTRY_LOW, 32'h77);
    rdchk(pcs_pkg::A_TOP_ENTRY_LOW, 32'h77);
    op(pcs_pkg::OP_RET, 0, 0);
    cmp("pc", 15'h0077, pc_out);
    $display("test circ done");
  endtask

  // Restart request, then interrupt wake with the global enable set
  task automatic t_wake();
    setpc(15'h1234);
    @(posedge aclk);
    restart_req <= 1;
    global_interrupt_enable <= 1;
    @(posedge aclk);
    restart_req <= 0;
    #1;
    cmp("pc", 0, pc_out);
    rdchk(pcs_pkg::A_LATCH, 0);
    rdchk(pcs_pkg::A_SP, 32'h1F);
    op(pcs_pkg::OP_WAKE, 0, 0);
    op(pcs_pkg::OP_SEQ, 0, 0);
    @(posedge aclk);
    #1;
    cmp("pc", 15'h0004, pc_out);
    rdchk(pcs_pkg::A_SP, 0);
    axr(8'hFC);
    cmp("rresp", pcs_pkg::RESP_SLVERR, rs);
    axw(8'hFC, 32'h1);
    cmp("bresp", pcs_pkg::RESP_SLVERR, rs);
    $display("test wake done");
  endtask

  // Window reads in every region, writes to traditional, window-register and program space
  task automatic t_win();
    win(16'h0123, 0, 0, 15'h0123, 0, 1, 0, 8'h86, 1);
    win(16'h204F, 1, 0, 15'h006F, 1, 1, 0, 8'hCA, 1);
    win(16'h2050, 1, 0, 15'h00A0, 1, 1, 0, 8'h05, 1);
    win(16'h8123, 0, 0, 15'h0123, 2, 1, 0, 8'hDC, 2);
    win(16'h29B0, 0, 0, 0, 3, 0, 0, 8'h00, 1);
    win(16'h0081, 1, 0, 0, 3, 0, 0, 8'h00, 1);
    win(16'h0123, 0, 1, 15'h0123, 0, 0, 1, 0, 1);
    win(16'h0000, 0, 1, 0, 0, 0, 0, 0, 1);
    win(16'h8010, 1, 1, 0, 2, 0, 0, 0, 1);
    $display("test window done");
  endtask

  // Prints counts and verdict, then ends the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_flow();
    t_branch();
    t_fault();
    t_circ();
    t_wake();
    t_win();
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #80000;
    bad_count++;
    print_verdict();
  end
endmodule
